// File: design/i2cmd_pkg.sv
// Purpose: Shared constants and types of the master-done flag block.
// Assumes: Avalon-MM byte addresses on a 4-bit address port.
// Notes:   Every offset and bit position, and the status and read-data reset values, live here.
package i2cmd_pkg;

    // Register byte offsets.
    localparam logic [3:0]  RAW_INTERRUPT_STATUS_ADDR   = 4'h0;
    localparam logic [3:0]  ICR_ADDR    = 4'h4;
    localparam logic [3:0]  MCR_ADDR    = 4'h8;
    localparam logic [3:0]  TSR_ADDR    = 4'hC;

    // Bit positions in the raw interrupt status and the clear register.
    localparam int          DONE_BIT    = 19;
    localparam int          WTT_BIT     = 18;
    localparam int          RFT_BIT     = 17;

    // Bit positions in the master command register.
    localparam int          CMD_GO_BIT  = 0;
    localparam int          CMD_RD_BIT  = 1;

    // Bit positions in the transaction status register.
    localparam int          TSR_RD_BIT  = 0;
    localparam int          TSR_BSY_BIT = 1;
    localparam int          TSR_REF_BIT = 2;
    localparam int          TSR_DEF_BIT = 3;

    // Reset values and the answer to an unmapped read.
    localparam logic [31:0] RAW_INTERRUPT_STATUS_RST    = 32'h0000_0000;
    localparam logic [31:0] RDATA_RST   = 32'h0000_0000;
    localparam logic [31:0] UNMAP_DATA  = 32'h0000_0000;

    // Master sequence, Gray coded along idle, busy, wait-for-stop.
    typedef enum logic [1:0] {
        I2CMD_IDLE  = 2'h0,
        I2CMD_BUSY  = 2'h1,
        I2CMD_WSTOP = 2'h3
    } i2cmd_mst_t;

endpackage

// File: design/i2cmd_link_if.sv
// Purpose: Carries sampled bus levels and bus conditions to the core.
// Assumes: All signals are in the core_clk_i domain.
// Notes:   Conditions are one-cycle pulses.
`timescale 1ns/10ps
interface i2cmd_link_if;
    logic scl_lvl;
    logic sda_lvl;
    logic start_p;
    logic stop_p;

    // The detector drives, the core listens.
    modport det  (output scl_lvl, output sda_lvl,
                  output start_p, output stop_p);
    modport core (input  scl_lvl, input  sda_lvl,
                  input  start_p, input  stop_p);
endinterface

// File: design/i2cmd_cond_det.sv
// Purpose: Samples the bus pins and finds start and stop conditions.
// Assumes: The pins are asynchronous to core_clk_i.
// Notes:   Two flops per pin before any decoding logic.
`timescale 1ns/10ps
module i2cmd_cond_det (
    input  wire logic   core_clk_i,
    input  wire logic   nrst_i,
    input  wire logic   scl_i,
    input  wire logic   sda_i,
    i2cmd_link_if.det   link
);

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic sda_s1;
        logic sda_s2;
        logic scl_d;
        logic sda_d;
        logic start_p;
        logic stop_p;
    } i2cmd_det_t;

    i2cmd_det_t det_ff;
    i2cmd_det_t nxt_det;

    // Synchronise both pins, then compare against the previous level.
    always_comb begin
        nxt_det         = det_ff;
        nxt_det.scl_s1  = scl_i;
        nxt_det.scl_s2  = det_ff.scl_s1;
        nxt_det.sda_s1  = sda_i;
        nxt_det.sda_s2  = det_ff.sda_s1;
        nxt_det.scl_d   = det_ff.scl_s2;
        nxt_det.sda_d   = det_ff.sda_s2;
        // A falling data line with the clock high is a start.
        nxt_det.start_p = det_ff.scl_s2 & det_ff.scl_d
                          & det_ff.sda_d & ~det_ff.sda_s2;
        // A rising data line with the clock high is a stop.
        nxt_det.stop_p  = det_ff.scl_s2 & det_ff.scl_d
                          & ~det_ff.sda_d & det_ff.sda_s2;
    end

    // Idle bus is high on both lines, so reset to ones.
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            det_ff <= '{scl_s1: 1'b1, scl_s2: 1'b1, sda_s1: 1'b1,
                        sda_s2: 1'b1, scl_d: 1'b1, sda_d: 1'b1,
                        start_p: 1'b0, stop_p: 1'b0};
        end else begin
            det_ff <= nxt_det;
        end
    end

    // Drive the interface from the registered state.
    assign link.scl_lvl = det_ff.scl_s2;
    assign link.sda_lvl = det_ff.sda_s2;
    assign link.start_p = det_ff.start_p;
    assign link.stop_p  = det_ff.stop_p;

endmodule

// File: design/i2cmd_top.sv
// Purpose: Master-done flag of a two-wire bus controller, with its
//          software handshake over an Avalon-MM slave.
// Assumes: The protocol engine sits outside and pulses its events.
// Notes:   One wait cycle on every bus access.
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
module i2cmd_top (
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             scl_o,
    output logic             scl_oe_o,
    output logic             eng_start_o,
    output logic             eng_read_o,
    input  wire logic        eng_master_end_i,
    input  wire logic        eng_slave_addr_i,
    input  wire logic        eng_slave_rd_i,
    output logic             master_done_flag_o
);

    i2cmd_link_if link ();

    i2cmd_cond_det u_det (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .link       (link)
    );

    typedef struct packed {
        i2cmd_pkg::i2cmd_mst_t mst;
        logic        done;
        logic        wtt;
        logic        rft;
        logic        defer;
        logic        defer_rd;
        logic        last_rd;
        logic        refused;
        logic        eng_start;
        logic        wait_r;
        logic        scl_low;
        logic [31:0] rdata;
    } i2cmd_st_t;

    i2cmd_st_t st_ff;
    i2cmd_st_t nxt_st;

    // Builds the raw interrupt status word.
    function automatic logic [31:0] raw_status(input i2cmd_st_t s);
        logic [31:0] v;
        v                      = i2cmd_pkg::RAW_INTERRUPT_STATUS_RST;
        v[i2cmd_pkg::DONE_BIT] = s.done;
        v[i2cmd_pkg::WTT_BIT]  = s.wtt;
        v[i2cmd_pkg::RFT_BIT]  = s.rft;
        return v;
    endfunction

    // Selects the word a read returns; unmapped offsets read as zero.
    function automatic logic [31:0] reg_read(input logic [3:0] a,
                                             input i2cmd_st_t s);
        logic [31:0] v;
        v = i2cmd_pkg::UNMAP_DATA;
        unique case (a)
            i2cmd_pkg::RAW_INTERRUPT_STATUS_ADDR: v = raw_status(s);
            i2cmd_pkg::TSR_ADDR: begin
                v[i2cmd_pkg::TSR_RD_BIT]  = s.last_rd;
                v[i2cmd_pkg::TSR_BSY_BIT] = (s.mst != i2cmd_pkg::I2CMD_IDLE);
                v[i2cmd_pkg::TSR_REF_BIT] = s.refused;
                v[i2cmd_pkg::TSR_DEF_BIT] = s.defer;
            end
            default: v = i2cmd_pkg::UNMAP_DATA;
        endcase
        return v;
    endfunction

    // Access strobes: an access takes effect when waitrequest is low.
    logic        acc_wr;
    logic        acc_rd;
    logic [31:0] clr;
    logic        go_wr;
    logic        set_done;

    assign acc_wr   = avs_write_i & ~st_ff.wait_r;
    assign acc_rd   = avs_read_i & ~st_ff.wait_r;
    assign clr      = (acc_wr && avs_address_i == i2cmd_pkg::ICR_ADDR)
                      ? avs_writedata_i : 32'h0000_0000;
    assign go_wr    = acc_wr && avs_address_i == i2cmd_pkg::MCR_ADDR
                      && avs_writedata_i[i2cmd_pkg::CMD_GO_BIT];
    assign set_done = (st_ff.mst == i2cmd_pkg::I2CMD_WSTOP) & link.stop_p;

    // Next-state logic for the bus slave, the flags and the sequence.
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.eng_start = 1'b0;
        nxt_st.wait_r    = 1'b1;
        nxt_st.scl_low   = 1'b0;

        // One wait cycle, then the answer with read data.
        if ((avs_read_i | avs_write_i) && st_ff.wait_r) begin
            nxt_st.wait_r = 1'b0;
        end
        if (avs_read_i && st_ff.wait_r) begin
            nxt_st.rdata = reg_read(avs_address_i, st_ff);
        end

        // Done flag: hardware set wins over a software clear.
        nxt_st.done = set_done
                      | (st_ff.done & ~clr[i2cmd_pkg::DONE_BIT]);

        // Master sequence; commands are refused while done pends.
        unique case (st_ff.mst)
            i2cmd_pkg::I2CMD_IDLE: begin
                if (go_wr && !st_ff.done) begin
                    nxt_st.mst       = i2cmd_pkg::I2CMD_BUSY;
                    nxt_st.eng_start = 1'b1;
                    nxt_st.last_rd   =
                        avs_writedata_i[i2cmd_pkg::CMD_RD_BIT];
                end
            end
            i2cmd_pkg::I2CMD_BUSY: begin
                if (eng_master_end_i) begin
                    nxt_st.mst = i2cmd_pkg::I2CMD_WSTOP;
                end
            end
            i2cmd_pkg::I2CMD_WSTOP: begin
                if (link.stop_p) begin
                    nxt_st.mst = i2cmd_pkg::I2CMD_IDLE;
                end
            end
            default: nxt_st.mst = i2cmd_pkg::I2CMD_IDLE;
        endcase

        // Refused-command mark, cleared by reading the transaction status word.
        if (acc_rd && avs_address_i == i2cmd_pkg::TSR_ADDR) begin
            nxt_st.refused = 1'b0;
        end
        if (go_wr && (st_ff.done
                      || st_ff.mst != i2cmd_pkg::I2CMD_IDLE)) begin
            nxt_st.refused = 1'b1;
        end

        // Target request flags, each cleared by its clear bit.
        nxt_st.wtt = st_ff.wtt & ~clr[i2cmd_pkg::WTT_BIT];
        nxt_st.rft = st_ff.rft & ~clr[i2cmd_pkg::RFT_BIT];
        if (eng_slave_addr_i && st_ff.done) begin
            nxt_st.defer    = 1'b1;
            nxt_st.defer_rd = eng_slave_rd_i;
        end else if (eng_slave_addr_i) begin
            nxt_st.wtt = nxt_st.wtt | ~eng_slave_rd_i;
            nxt_st.rft = nxt_st.rft | eng_slave_rd_i;
        end else if (st_ff.defer && !st_ff.done) begin
            // Release the deferred notification once acknowledged.
            nxt_st.defer = 1'b0;
            nxt_st.wtt   = nxt_st.wtt | ~st_ff.defer_rd;
            nxt_st.rft   = nxt_st.rft | st_ff.defer_rd;
        end
    end

    // State register; the bus sees waitrequest high under reset.
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff <= '{mst: i2cmd_pkg::I2CMD_IDLE, done: 1'b0,
                       wtt: 1'b0, rft: 1'b0, defer: 1'b0,
                       defer_rd: 1'b0, last_rd: 1'b0, refused: 1'b0,
                       eng_start: 1'b0, wait_r: 1'b1, scl_low: 1'b0,
                       rdata: i2cmd_pkg::RDATA_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register.
    assign avs_readdata_o     = st_ff.rdata;
    assign avs_waitrequest_o  = st_ff.wait_r;
    assign scl_o              = st_ff.scl_low;
    assign scl_oe_o           = st_ff.defer;
    assign eng_start_o        = st_ff.eng_start;
    assign eng_read_o         = st_ff.last_rd;
    assign master_done_flag_o = st_ff.done;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    // The flag follows a stop seen after the engine ended.
    chk_done_sets: assert property (set_done |=> st_ff.done)
        else $error("done flag did not set after stop");

    // The flag may only fall on a clear write with its bit set.
    chk_done_clear_only: assert property ($fell(st_ff.done) |->
        $past(acc_wr && avs_address_i == i2cmd_pkg::ICR_ADDR
              && avs_writedata_i[i2cmd_pkg::DONE_BIT]))
        else $error("done flag fell without a clear write");

    // A clear write drops the flag on the next edge unless re-set.
    chk_done_clears: assert property ((st_ff.done && !set_done
        && clr[i2cmd_pkg::DONE_BIT]) |=> !st_ff.done)
        else $error("done flag survived its clear");

    // A command start never follows a pending done flag.
    chk_cmd_gated: assert property (go_wr && st_ff.done |=>
        !eng_start_o ##1 st_ff.refused || !eng_start_o)
        else $error("command accepted while done pending");

    // Addressed while pending: stretch and keep requests down.
    chk_defer_stretch: assert property ((st_ff.done && eng_slave_addr_i
        && !st_ff.wtt && !st_ff.rft) |=> scl_oe_o && !st_ff.wtt
        && !st_ff.rft)
        else $error("target request not deferred");

    // Raw status read shows the flag at its bit position.
    chk_flag_bit: assert property ((avs_read_i && st_ff.wait_r
        && avs_address_i == i2cmd_pkg::RAW_INTERRUPT_STATUS_ADDR) |=>
        avs_readdata_o[i2cmd_pkg::DONE_BIT] == $past(st_ff.done))
        else $error("raw status bit does not show done flag");

    // Addressed for a write with nothing pending raises the request.
    chk_wtt_raise: assert property ((eng_slave_addr_i && !st_ff.done
        && !eng_slave_rd_i) |=> st_ff.wtt)
        else $error("write-to-target request not raised");

    // An accepted command never follows a pending flag.
    chk_start_gated: assert property (eng_start_o |->
        $past(go_wr && !st_ff.done))
        else $error("command started while done pending");

    // The start strobe to the engine lasts exactly one cycle.
    chk_start_pulse: assert property (eng_start_o |=>
        !eng_start_o)
        else $error("engine start longer than one cycle");

    // The direction handed to the engine is the one just written.
    chk_dir_latched: assert property (eng_start_o |->
        eng_read_o == $past(avs_writedata_i[i2cmd_pkg::CMD_RD_BIT]))
        else $error("command direction not latched");

    // A command written while the flag pends is marked as refused.
    chk_refused_mark: assert property ((go_wr && st_ff.done) |=>
        st_ff.refused)
        else $error("refused command not marked");

    // The flag stays up until a clear write carries its bit.
    chk_done_holds: assert property ((st_ff.done
        && !clr[i2cmd_pkg::DONE_BIT]) |=> st_ff.done)
        else $error("done flag dropped without clear");

    // Once acknowledged, the deferred request rises and the line frees.
    chk_defer_release: assert property ((st_ff.defer
        && !st_ff.done && !eng_slave_addr_i) |=>
        !scl_oe_o && (st_ff.wtt || st_ff.rft))
        else $error("deferred request not released");

    // While the clock pin is driven, it is driven low.
    chk_scl_low_value: assert property (scl_oe_o |-> !scl_o)
        else $error("clock pin driven high");

    cov_done_set:   cover property (set_done ##1 st_ff.done);
    cov_clear:      cover property (st_ff.done ##[1:50] !st_ff.done);
    cov_deferred:   cover property (st_ff.defer ##[1:50] !st_ff.defer);
    cov_refused:    cover property (go_wr && st_ff.done);

endmodule

// File: dv/i2cmd_far_model.sv
// Purpose: Far side of the block: engine end pulse and bus pin levels.
// Assumes: Both pins idle high through pull-ups.
// Notes:   The link clock moves only inside a frame, 80 ns a period.
`timescale 1ns/10ps
module i2cmd_far_model (
    input  wire logic       core_clk_i,
    input  wire logic       eng_start_i,
    input  wire logic [7:0] lag_i,
    output logic            scl_o,
    output logic            sda_o,
    output logic            eng_master_end_o
);
    // Waits half a link clock period.
    task automatic half();
        repeat (4) @(posedge core_clk_i);
    endtask

    // Both lines start released high.
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        eng_master_end_o = 1'b0;
    end

    // After the lag, ends the operation, then frames a closing stop.
    always @(posedge core_clk_i) begin
        if (eng_start_i === 1'b1) begin
            repeat (lag_i) @(posedge core_clk_i);
            eng_master_end_o <= 1'b1;
            @(posedge core_clk_i);
            eng_master_end_o <= 1'b0;
            sda_o <= 1'b0;
            half();
            scl_o <= 1'b0;
            half();
            scl_o <= 1'b1;
            half();
            sda_o <= 1'b1;
        end
    end
endmodule

// File: dv/i2cmd_top_test.sv
// Purpose: Self-checking bench of the master-done flag block.
// Assumes: Far side modelled in its own module, pins pulled up.
// Notes:   Each scenario is one task; waits are bounded.
`timescale 1ns/10ps
module i2cmd_top_test;
    logic        core_clk;
    logic        nrst;
    logic [3:0]  address;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        waitreq;
    logic        scl_m;
    logic        sda_m;
    logic        scl_w;
    logic        scl_drv;
    logic        scl_oe;
    logic        start_p;
    logic        rd_dir;
    logic        m_end;
    logic        s_addr;
    logic        s_rd;
    logic        done;
    logic [7:0]  lag;
    logic [31:0] got;
    int          mismatches;
    int          cmp_count;
    int          starts;

    // Clock line level: the block pulls low, else the far side sets it.
    assign scl_w = (scl_oe === 1'b1) ? 1'b0 : scl_m;

    i2cmd_top dut (
        .core_clk_i(core_clk), .nrst_i(nrst), .avs_address_i(address),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .scl_i(scl_w), .sda_i(sda_m), .scl_o(scl_drv), .scl_oe_o(scl_oe),
        .eng_start_o(start_p), .eng_read_o(rd_dir),
        .eng_master_end_i(m_end), .eng_slave_addr_i(s_addr),
        .eng_slave_rd_i(s_rd), .master_done_flag_o(done)
    );

    i2cmd_far_model far (
        .core_clk_i(core_clk), .eng_start_i(start_p), .lag_i(lag),
        .scl_o(scl_m), .sda_o(sda_m), .eng_master_end_o(m_end)
    );

    // Free-running core clock.
    always #5 core_clk = ~core_clk;

    // Counts accepted master commands.
    always @(posedge core_clk) begin
        if (start_p === 1'b1) begin
            starts <= starts + 1;
        end
    end

    task automatic end_sim();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] act, exp, input string what);
        cmp_count++;
        if (act !== exp) begin
            mismatches++;
            $display("ERROR %0t %s got %h want %h", $time, what, act, exp);
        end
    endtask

    // One bus access; holds the request until waitrequest is seen low.
    task automatic av(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge core_clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        got = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge core_clk);
        if (n >= 50) begin
            mismatches++;
            end_sim();
        end
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 300) begin
            mismatches++;
            end_sim();
        end
    endtask

    task automatic t_reset();
        check({31'h0, done}, 32'h0, "done after reset");
        av(1'b0, i2cmd_pkg::RAW_INTERRUPT_STATUS_ADDR, 32'h0);
        check(got, i2cmd_pkg::RAW_INTERRUPT_STATUS_RST, "raw status reset");
        av(1'b0, 4'h2, 32'h0);
        check(got, i2cmd_pkg::UNMAP_DATA, "unmapped read");
    endtask

    task automatic t_master(input logic rdir, input logic [7:0] lg);
        int n0;
        n0 = starts;
        lag <= lg;
        av(1'b1, i2cmd_pkg::MCR_ADDR, {30'h0, rdir, 1'b1});
        check({31'h0, done}, 32'h0, "done before stop");
        wait_done();
        check(starts, n0 + 1, "command accepted");
        check({31'h0, rd_dir}, {31'h0, rdir}, "direction");
        av(1'b0, i2cmd_pkg::RAW_INTERRUPT_STATUS_ADDR, 32'h0);
        check(got, 32'h1 << i2cmd_pkg::DONE_BIT, "done bit");
        av(1'b0, i2cmd_pkg::TSR_ADDR, 32'h0);
        check({31'h0, got[i2cmd_pkg::TSR_RD_BIT]}, {31'h0, rdir}, "last rd");
    endtask

    task automatic t_refuse();
        int n0;
        n0 = starts;
        av(1'b1, i2cmd_pkg::MCR_ADDR, 32'h1);
        repeat (3) @(posedge core_clk);
        check(starts, n0, "command while done");
        av(1'b0, i2cmd_pkg::TSR_ADDR, 32'h0);
        check({31'h0, got[i2cmd_pkg::TSR_REF_BIT]}, 32'h1, "refused");
    endtask

    task automatic t_clear();
        av(1'b1, i2cmd_pkg::RAW_INTERRUPT_STATUS_ADDR, 32'hFFFF_FFFF);
        check({31'h0, done}, 32'h1, "status is read-only");
        av(1'b1, i2cmd_pkg::ICR_ADDR, ~(32'h1 << i2cmd_pkg::DONE_BIT));
        check({31'h0, done}, 32'h1, "other clear bits");
        av(1'b1, i2cmd_pkg::ICR_ADDR, 32'h1 << i2cmd_pkg::DONE_BIT);
        check({31'h0, done}, 32'h0, "clear by one");
        av(1'b0, i2cmd_pkg::RAW_INTERRUPT_STATUS_ADDR, 32'h0);
        check(got, 32'h0, "status after clear");
    endtask

    // Addressed as target for one cycle; rdv is the direction, one for a read.
    task automatic hit(input logic rdv);
        s_rd <= rdv;
        s_addr <= 1'b1;
        @(posedge core_clk);
        s_addr <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic t_defer(input logic rdv);
        int b;
        b = rdv ? i2cmd_pkg::RFT_BIT : i2cmd_pkg::WTT_BIT;
        hit(rdv);
        check({31'h0, scl_oe}, 32'h1, "clock held low");
        check({31'h0, scl_w}, 32'h0, "clock line level");
        check({31'h0, scl_drv}, 32'h0, "clock drive value");
        av(1'b0, i2cmd_pkg::RAW_INTERRUPT_STATUS_ADDR, 32'h0);
        check({31'h0, got[b]}, 32'h0, "request deferred");
        av(1'b1, i2cmd_pkg::ICR_ADDR, 32'h1 << i2cmd_pkg::DONE_BIT);
        av(1'b0, i2cmd_pkg::RAW_INTERRUPT_STATUS_ADDR, 32'h0);
        check(got, 32'h1 << b, "request after clear");
        check({31'h0, scl_oe}, 32'h0, "clock released");
        av(1'b1, i2cmd_pkg::ICR_ADDR, 32'h1 << b);
    endtask

    task automatic t_direct();
        hit(1'b0);
        check({31'h0, scl_oe}, 32'h0, "no stretch");
        av(1'b0, i2cmd_pkg::RAW_INTERRUPT_STATUS_ADDR, 32'h0);
        check(got, 32'h1 << i2cmd_pkg::WTT_BIT, "write request");
    endtask

    // Reset, then every scenario in turn.
    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        address = 4'h0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        s_addr = 1'b0;
        s_rd = 1'b0;
        lag = 8'h2;
        mismatches = 0;
        cmp_count = 0;
        starts = 0;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_master(1'b0, 8'h2);
        t_refuse();
        t_clear();
        t_master(1'b1, 8'h1E);
        t_defer(1'b1);
        t_master(1'b0, 8'h0);
        t_defer(1'b0);
        t_direct();
        end_sim();
    end
endmodule
